// ===== verilog/sac_pkg.sv
// Purpose: Shared constants and types of the serial SAR conversion control
// Assumes: Host serial clock and strobe are synchronous to clk
// Notes:   Cycle numbers count falling edges of the host serial clock
package sac_pkg;

    // ************************************************************
    // Result and cycle constants
    // ************************************************************
    localparam int          RES_BITS     = 12;
    localparam logic [3:0]  MSB_IDX      = 4'hb;
    localparam logic [3:0]  IDLE_CYCLE   = 4'h0;
    localparam logic [3:0]  FIRST_CYCLE  = 4'h1;
    localparam logic [3:0]  LAST_DECIDE  = 4'hc;
    localparam logic [3:0]  LAST_CYCLE   = 4'hd;
    localparam logic [3:0]  REPEAT_BITS  = 4'hb;
    localparam logic [11:0] CODE_RESET   = 12'h000;

    // ************************************************************
    // Control states
    // ************************************************************
    typedef enum logic [3:0] {
        SAC_IDLE   = 4'h1,
        SAC_CONVERSION_STROBE   = 4'h2,
        SAC_REPEAT = 4'h4,
        SAC_PDOWN  = 4'h8
    } sac_state_e;

endpackage

// ===== verilog/sac_sar_reg.sv
// Purpose: Successive approximation register holding decided bits
// Assumes: One decision per request, index counting down from the MSB
// Notes:   Trial code feeds the internal DAC of the comparator
`timescale 1ns/10ps

module sac_sar_reg (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        clear,
    input  wire logic        decide,
    input  wire logic [3:0]  bit_idx,
    input  wire logic        comp_high,
    output logic      [11:0] code,
    output logic      [11:0] trial
);

    typedef struct packed {
        logic [11:0] code;
        logic [11:0] trial;
    } sac_sar_s;

    sac_sar_s s;
    sac_sar_s next_s;
    logic [11:0] mask;

    function automatic logic [11:0] bit_mask(input logic [3:0] idx);
        logic [11:0] m;
        m = 12'h000;
        for (int i = 0; i < sac_pkg::RES_BITS; i++) begin
            if (idx == 4'(i)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s = s;
        mask   = bit_mask(bit_idx);
        if (clear) begin
            next_s.code  = sac_pkg::CODE_RESET;
            next_s.trial = bit_mask(sac_pkg::MSB_IDX);
        end else if (decide) begin
            // Comparator high keeps the bit: code 0 is the lowest input
            next_s.code = comp_high ? (s.code | mask)
                                    : (s.code & ~mask);
            next_s.trial = next_s.code;
            if (bit_idx != 4'h0) begin
                next_s.trial = next_s.code | bit_mask(bit_idx - 4'h1);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign code  = s.code;
    assign trial = s.trial;

    // ************************************************************
    // Checks
    // ************************************************************
    a_straight_bin: assert property (@(posedge clk) disable iff (!nrst)
        (decide && !clear) |=> (code[$past(bit_idx)] == $past(comp_high)))
        else $error("decided bit differs from comparator");

endmodule

// ===== verilog/sac_conversion_strobe_ctrl.sv
// Purpose: Conversion control and serial result output of a 12-bit SAR
// Assumes: strobe and serial clock sampled as synchronous inputs
// Notes:   Data line is two signals, data_out and data_oe; the pad resolves the level
`timescale 1ns/10ps

// Summary of operation
// - Short-cycle ends conversion, undecided bits dropped
// - Strobe rise then fall before 13th aborts
// - Strobe fall in 13th cycle enters repeat
// - Strobe fall floats data line at once
// - Result coded as straight unsigned binary
// - Strobe fall puts sampler into hold
// - Strobe low at 13th start: power-down
// - Repeat mode resends 11 bits, LSB first
// - First cycle drives data line low
module sac_conversion_strobe_ctrl (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        conversion_strobe,
    input  wire logic        serial_clock,
    input  wire logic        comp_high,
    output logic             data_out,
    output logic             data_oe,
    output logic             hold,
    output logic             power_down,
    output logic      [11:0] dac_trial,
    output logic      [11:0] result,
    output logic             result_valid,
    output logic             short_cycle_done
);

    typedef struct packed {
        sac_pkg::sac_state_e state;
        logic [3:0]          cyc;
        logic [3:0]          rep;
        logic                sclk_q;
        logic                strobe_q;
        logic                data_out;
        logic                data_oe;
        logic                hold;
        logic                power_down;
        logic [11:0]         result;
        logic                result_valid;
        logic                short_done;
    } sac_ctrl_s;

    sac_ctrl_s   s;
    sac_ctrl_s   next_s;
    logic        strobe_fall;
    logic        strobe_rise;
    logic        sclk_fall;
    logic        sar_clear;
    logic        sar_decide;
    logic [3:0]  sar_idx;
    logic [11:0] sar_code;
    logic [3:0]  rep_idx;

    // ************************************************************
    // Edge detection
    // ************************************************************
    assign strobe_fall = s.strobe_q & ~conversion_strobe;
    assign strobe_rise = ~s.strobe_q & conversion_strobe;
    assign sclk_fall   = s.sclk_q & ~serial_clock;
    assign rep_idx     = s.rep + 4'h1;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s              = s;
        next_s.sclk_q       = serial_clock;
        next_s.strobe_q     = conversion_strobe;
        next_s.result_valid = 1'b0;
        next_s.short_done   = 1'b0;
        sar_clear           = 1'b0;
        sar_decide          = 1'b0;
        sar_idx             = 4'h0;
        // Strobe events take priority over a coincident clock fall
        unique case (s.state)
            sac_pkg::SAC_IDLE: begin
                next_s.hold       = 1'b0;
                next_s.power_down = 1'b0;
                if (strobe_fall) begin
                    next_s.state = sac_pkg::SAC_CONVERSION_STROBE;
                    next_s.cyc   = sac_pkg::IDLE_CYCLE;
                    next_s.hold  = 1'b1;
                    sar_clear    = 1'b1;
                end
            end
            sac_pkg::SAC_CONVERSION_STROBE: begin
                if (strobe_fall && s.cyc < sac_pkg::LAST_CYCLE) begin
                    // Reduced result; the fall also starts the next one
                    next_s.result       = sar_code;
                    next_s.result_valid = 1'b1;
                    next_s.short_done   = 1'b1;
                    next_s.cyc          = sac_pkg::IDLE_CYCLE;
                    next_s.data_oe      = 1'b0;
                    next_s.hold         = 1'b1;
                    sar_clear           = 1'b1;
                end else if (strobe_fall) begin
                    next_s.state        = sac_pkg::SAC_REPEAT;
                    next_s.rep          = 4'h0;
                    next_s.data_oe      = 1'b0;
                    next_s.power_down   = 1'b1;
                    next_s.result       = sar_code;
                    next_s.result_valid = 1'b1;
                end else if (sclk_fall) begin
                    next_s.cyc = s.cyc + 4'h1;
                    if (s.cyc == sac_pkg::IDLE_CYCLE) begin
                        next_s.data_oe  = 1'b1;
                        next_s.data_out = 1'b0;
                    end else if (s.cyc <= sac_pkg::LAST_DECIDE) begin
                        sar_decide      = 1'b1;
                        sar_idx         = sac_pkg::LAST_DECIDE - s.cyc;
                        next_s.data_oe  = 1'b1;
                        next_s.data_out = comp_high;
                        if (s.cyc == sac_pkg::LAST_DECIDE &&
                            !conversion_strobe) begin
                            next_s.power_down = 1'b1;
                        end
                    end else begin
                        next_s.data_oe      = 1'b0;
                        next_s.hold         = 1'b0;
                        next_s.result       = sar_code;
                        next_s.result_valid = 1'b1;
                        next_s.state = s.power_down ? sac_pkg::SAC_PDOWN
                                                    : sac_pkg::SAC_IDLE;
                    end
                end
            end
            sac_pkg::SAC_REPEAT: begin
                if (strobe_rise) begin
                    next_s.state   = sac_pkg::SAC_IDLE;
                    next_s.data_oe = 1'b0;
                    next_s.hold    = 1'b0;
                end else if (sclk_fall && s.rep < sac_pkg::REPEAT_BITS) begin
                    next_s.rep      = rep_idx;
                    next_s.data_oe  = 1'b1;
                    next_s.data_out = sar_code[rep_idx];
                end else if (sclk_fall) begin
                    next_s.state   = sac_pkg::SAC_PDOWN;
                    next_s.data_oe = 1'b0;
                end
            end
            sac_pkg::SAC_PDOWN: begin
                next_s.data_oe = 1'b0;
                next_s.hold    = 1'b0;
                if (strobe_rise) begin
                    next_s.state      = sac_pkg::SAC_IDLE;
                    next_s.power_down = 1'b0;
                end
            end
            default: begin
                next_s.state   = sac_pkg::SAC_IDLE;
                next_s.data_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s          <= '0;
            s.state    <= sac_pkg::SAC_IDLE;
            s.sclk_q   <= 1'b1;
            s.strobe_q <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Decision register
    // ************************************************************
    sac_sar_reg u_sar (
        .clk       (clk),
        .nrst      (nrst),
        .clear     (sar_clear),
        .decide    (sar_decide),
        .bit_idx   (sar_idx),
        .comp_high (comp_high),
        .code      (sar_code),
        .trial     (dac_trial)
    );

    assign data_out         = s.data_out;
    assign data_oe          = s.data_oe;
    assign hold             = s.hold;
    assign power_down       = s.power_down;
    assign result           = s.result;
    assign result_valid     = s.result_valid;
    assign short_cycle_done = s.short_done;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_float_on_fall: assert property (strobe_fall |=> !data_oe)
        else $error("data line driven after strobe fall");
    a_hold_on_fall: assert property (strobe_fall |=> hold)
        else $error("sampler not in hold after strobe fall");
    a_short_result: assert property (
        (s.state == sac_pkg::SAC_CONVERSION_STROBE && strobe_fall &&
         s.cyc < sac_pkg::LAST_CYCLE)
        |=> (result_valid && result == $past(sar_code)))
        else $error("short cycle result missing");
    a_short_restart: assert property (
        (s.state == sac_pkg::SAC_CONVERSION_STROBE && strobe_fall &&
         s.cyc < sac_pkg::LAST_CYCLE)
        |=> (short_cycle_done && s.cyc == sac_pkg::IDLE_CYCLE &&
             s.state == sac_pkg::SAC_CONVERSION_STROBE))
        else $error("short cycle did not abort");
    a_repeat_entry: assert property (
        (s.state == sac_pkg::SAC_CONVERSION_STROBE && strobe_fall &&
         s.cyc == sac_pkg::LAST_CYCLE)
        |=> (s.state == sac_pkg::SAC_REPEAT && !short_cycle_done))
        else $error("repeat mode not entered");
    a_pdown_entry: assert property (
        (s.state == sac_pkg::SAC_CONVERSION_STROBE && sclk_fall && !strobe_fall &&
         s.cyc == sac_pkg::LAST_DECIDE && !conversion_strobe)
        |=> power_down ##1 power_down)
        else $error("power-down missed at 13th cycle");
    a_repeat_lsb: assert property (
        (s.state == sac_pkg::SAC_REPEAT && sclk_fall && !strobe_rise &&
         s.rep < sac_pkg::REPEAT_BITS)
        |=> (data_oe && data_out == sar_code[s.rep]))
        else $error("repeat bit wrong");
    a_first_low: assert property (
        (s.state == sac_pkg::SAC_CONVERSION_STROBE && sclk_fall && !strobe_fall &&
         s.cyc == sac_pkg::IDLE_CYCLE) |=> (data_oe && !data_out))
        else $error("first cycle not driven low");

    c_full_conversion_strobe:   cover property (result_valid && !short_cycle_done);
    c_short_cycle: cover property (short_cycle_done);
    c_repeat:      cover property (s.state == sac_pkg::SAC_REPEAT &&
                                   s.rep == sac_pkg::REPEAT_BITS);
    c_pdown:       cover property (s.state == sac_pkg::SAC_PDOWN);

endmodule

// ===== verification/sac_host_model.sv
// Purpose: Host serial port model driving strobe and serial clock
// Assumes: Host drives at falling clk edges; data line has a pull-up
// Notes:   Serial clock stands high between frames
`timescale 1ns/10ps

module sac_host_model #(
    parameter int HALF_CYC = 2
) (
    input  wire logic clk,
    input  wire logic data_out,
    input  wire logic data_oe,
    output logic      conversion_strobe,
    output logic      serial_clock
);
    // ************************************************************
    // Data line with pull-up
    // ************************************************************
    wire logic data_line;

    // Pull-up shows the start bit leaving high impedance
    assign data_line = data_oe ? data_out : 1'b1;

    initial begin
        conversion_strobe = 1'b1;
        serial_clock = 1'b1;
    end

    // ************************************************************
    // Host actions
    // ************************************************************
    task automatic set_strobe(input logic v);
        @(negedge clk);
        conversion_strobe = v;
    endtask

    // First clock follows at once, well inside the droop limit
    task automatic start_conversion_strobe;
        set_strobe(1'b0);
    endtask

    // Fixed period, never near the slow limit; sample before next fall
    task automatic clock_cycle(output logic d, output logic oe);
        @(negedge clk);
        serial_clock = 1'b0;
        repeat (HALF_CYC) @(negedge clk);
        serial_clock = 1'b1;
        repeat (HALF_CYC) @(negedge clk);
        d = data_line;
        oe = data_oe;
    endtask
endmodule

// ===== verification/testbench.sv
// Purpose: Self-checking bench of the serial SAR conversion control
// Assumes: Comparator modelled as input code against the trial code
// Notes:   Result pulses are counted by a monitor on falling edges
`timescale 1ns/10ps

module testbench;
    logic        clk;
    logic        nrst;
    logic        comp_high;
    logic [11:0] vin;
    logic        conversion_strobe;
    logic        serial_clock;
    logic        data_out;
    logic        data_oe;
    logic        hold;
    logic        power_down;
    logic [11:0] dac_trial;
    logic [11:0] result;
    logic        result_valid;
    logic        short_cycle_done;
    int          n_mismatch;
    int          check_count;
    int          n_valid = 0;
    logic        last_short = 1'b0;

    sac_conversion_strobe_ctrl sac_conversion_strobe_ctrl_inst (
        .clk               (clk),
        .nrst              (nrst),
        .conversion_strobe (conversion_strobe),
        .serial_clock      (serial_clock),
        .comp_high         (comp_high),
        .data_out          (data_out),
        .data_oe           (data_oe),
        .hold              (hold),
        .power_down        (power_down),
        .dac_trial         (dac_trial),
        .result            (result),
        .result_valid      (result_valid),
        .short_cycle_done  (short_cycle_done)
    );

    sac_host_model sac_host_model_inst (
        .clk               (clk),
        .data_out          (data_out),
        .data_oe           (data_oe),
        .conversion_strobe (conversion_strobe),
        .serial_clock      (serial_clock)
    );

    // ************************************************************
    // Clock, comparator and result monitor
    // ************************************************************
    initial clk = 1'b0;
    always #4 clk = ~clk;

    // Updated off the sampling edge to avoid a race
    always @(negedge clk) comp_high <= (vin >= dac_trial);

    always @(negedge clk) begin
        if (result_valid === 1'b1) begin
            n_valid = n_valid + 1;
            last_short = short_cycle_done;
        end
    end

    // ************************************************************
    // Compare and closing tasks
    // ************************************************************
    task automatic check_bit(input logic got, input logic exp,
                             input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic check_word(input logic [11:0] got,
                              input logic [11:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic full_conversion_strobe(input logic [11:0] code, input bit started);
        logic d;
        logic oe;
        int   v0;
        vin = code;
        v0 = n_valid;
        if (!started) sac_host_model_inst.start_conversion_strobe();
        sac_host_model_inst.clock_cycle(d, oe);
        check_bit(oe, 1'b1, "start enable");
        check_bit(d, 1'b0, "start low");
        check_bit(hold, 1'b1, "hold in conversion");
        sac_host_model_inst.set_strobe(1'b1);
        for (int n = 11; n >= 0; n--) begin
            sac_host_model_inst.clock_cycle(d, oe);
            check_bit(d, code[n], "result bit");
        end
        sac_host_model_inst.clock_cycle(d, oe);
        check_bit(oe, 1'b0, "float after frame");
        check_bit(hold, 1'b0, "track after frame");
        check_bit(n_valid == v0 + 1, 1'b1, "one result pulse");
        check_bit(last_short, 1'b0, "no abort flag");
        check_word(result, code, "full result");
    endtask

    task automatic short_cycle(input logic [11:0] code);
        logic d;
        logic oe;
        vin = code;
        sac_host_model_inst.start_conversion_strobe();
        repeat (6) sac_host_model_inst.clock_cycle(d, oe);
        sac_host_model_inst.set_strobe(1'b1);
        sac_host_model_inst.set_strobe(1'b0);
        repeat (2) @(negedge clk);
        check_bit(data_oe, 1'b0, "float on strobe fall");
        check_bit(last_short, 1'b1, "abort flag");
        check_word(result, code & 12'hf80, "reduced");
        check_bit(hold, 1'b1, "new hold");
        full_conversion_strobe(code, 1'b1);
    endtask

    task automatic power_down_run(input logic [11:0] code);
        logic d;
        logic oe;
        vin = code;
        sac_host_model_inst.start_conversion_strobe();
        repeat (13) sac_host_model_inst.clock_cycle(d, oe);
        check_bit(power_down, 1'b1, "power-down entry");
        sac_host_model_inst.clock_cycle(d, oe);
        check_bit(oe, 1'b0, "float in power-down");
        check_bit(power_down, 1'b1, "power-down stays");
        check_word(result, code, "power-down result");
        sac_host_model_inst.set_strobe(1'b1);
        repeat (2) @(negedge clk);
        check_bit(power_down, 1'b0, "wake on strobe rise");
    endtask

    task automatic lsb_repeat(input logic [11:0] code);
        logic d;
        logic oe;
        vin = code;
        sac_host_model_inst.start_conversion_strobe();
        repeat (4) sac_host_model_inst.clock_cycle(d, oe);
        sac_host_model_inst.set_strobe(1'b1);
        repeat (9) sac_host_model_inst.clock_cycle(d, oe);
        sac_host_model_inst.set_strobe(1'b0);
        for (int j = 1; j <= 11; j++) begin
            sac_host_model_inst.clock_cycle(d, oe);
            check_bit(oe, 1'b1, "repeat enable");
            check_bit(d, code[j], "repeat bit");
        end
        check_word(result, code, "repeat result");
        sac_host_model_inst.clock_cycle(d, oe);
        check_bit(oe, 1'b0, "float after repeat");
        check_bit(power_down, 1'b1, "power-down after repeat");
        sac_host_model_inst.set_strobe(1'b1);
        repeat (2) @(negedge clk);
        check_bit(power_down, 1'b0, "wake after repeat");
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        nrst = 1'b0;
        vin = 12'h000;
        n_mismatch = 0;
        check_count = 0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        check_bit(data_oe, 1'b0, "reset float");
        check_bit(hold, 1'b0, "reset tracking");
        check_word(result, 12'h000, "reset result");
        full_conversion_strobe(12'h000, 1'b0);
        full_conversion_strobe(12'hfff, 1'b0);
        full_conversion_strobe(12'ha5c, 1'b0);
        short_cycle(12'hb6d);
        power_down_run(12'h7ff);
        lsb_repeat(12'h3c6);
        end_sim;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("[FAIL] %0t run did not finish", $time);
        end_sim;
    end
endmodule
